// ---- inc/emd_pkg.sv ----
// energy metering datapath: shared constants, carriers and state codes
// assumes one 100 MHz core clock; the master clock rate is a derived enable
package emd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking and timing
  localparam int unsigned CORE_CLK_HZ   = 100_000_000;
  localparam int unsigned MCLK_HZ       = 3_579_545;
  localparam int unsigned MCLK_DIV      = CORE_CLK_HZ / MCLK_HZ;
  localparam int          MCLK_CNT_W    = 5;
  localparam int          MCLK_PER_TICK = 4;
  localparam int          TICK_CNT_W    = 2;
  localparam int          TICKS_PER_ADC = 32;
  localparam int          ADC_CNT_W     = 5;
  localparam int          DEC_CNT_W     = 3;

  ////////////////////////////////////////////////////////////////////////////
  // data widths and scaling
  localparam int ADC_W       = 20;
  localparam int GAIN_W      = 12;
  localparam int GAIN_FRAC   = 12;
  localparam int GPROD_W     = ADC_W + GAIN_W;
  localparam int SC_W        = 21;
  localparam int PROD_W      = SC_W + ADC_W;
  localparam int POWER_SHIFT = 18;
  localparam int POWER_W     = 24;
  localparam int WAVE_W      = 24;
  localparam int ENERGY_W    = 40;
  localparam int CH2_WAVE_LOWPASS_SHIFT  = 10;
  localparam int CH2_WAVE_LOWPASS_ACC_W  = 32;
  localparam int POWER_LOWPASS_SHIFT  = 14;
  localparam int POWER_LOWPASS_ACC_W  = 40;

  ////////////////////////////////////////////////////////////////////////////
  // phase trim delay line
  localparam int             TRIM_W     = 6;
  localparam int             TRIM_REG_W = 8;
  localparam int             RING_DEPTH = 64;
  localparam int             RING_AW    = 6;
  localparam logic [6:0]     DELAY_MID  = 7'h21;

  ////////////////////////////////////////////////////////////////////////////
  // mode register fields
  localparam int         MODE_W        = 16;
  localparam int         MODE_CAP_LSB  = 13;
  localparam int         MODE_RATE_LSB = 11;
  localparam logic [1:0] CAP_POWER     = 2'h0;
  localparam logic [1:0] CAP_CH1       = 2'h2;
  localparam logic [1:0] CAP_CH2       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // buffering and reset values
  localparam int                   FIFO_DEPTH = 8;
  localparam logic [ENERGY_W-1:0]  ENERGY_RST = 40'h00_0000_0000;

  typedef struct packed {
    logic signed [ADC_W-1:0] ch1;
    logic signed [ADC_W-1:0] ch2;
  } emd_pair_s;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } emd_byte_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_HI   = 2'b01,
    RD_MID  = 2'b10,
    RD_LO   = 2'b11
  } emd_rd_e;

endpackage : emd_pkg

// ---- hdl/emd_fifo.sv ----
// emd_fifo: flip-flop fifo for waveform words, valid/ready on both sides
// assumes the same core clock and synchronous active-low reset as the top
`timescale 1ns/100ps
module emd_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int             AW       = $clog2(DEPTH);
  localparam logic [AW:0]    FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } emd_fifo_s;

  emd_fifo_s s;
  emd_fifo_s next_s;
  logic      push;
  logic      pop;

  assign in_ready  = (s.wp - s.rp) != FULL_CNT;
  assign out_valid = s.wp != s.rp;
  assign out_data  = s.mem[s.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp                = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  fifo_no_overfill_a: assert property ((s.wp - s.rp) <= FULL_CNT)
    else $error("fifo holds more words than its depth");

endmodule : emd_fifo

// ---- hdl/emd_datapath.sv ----
// emd_datapath: phase trim, power multiply, low-pass filters, energy
// accumulation and waveform capture of a single-phase energy meter
// assumes adc codes and register values are synchronous to core_clk
`timescale 1ns/100ps

// Contract
// - ch2 capture mode routes ch2 to waveform
// - ch2 waveform path has 156Hz single-pole lowpass
// - multiplier takes unfiltered ch2 adc samples
// - four capture rates chosen by mode bits 12:11
// - new waveform sample drives active-low interrupt
// - both channel paths share matched delay
// - 6-bit signed trim shifts ch2 four-clock steps
// - negative trim advances ch2; 3Fh one step
// - power is lowpassed voltage times current product
// - power range follows gain trim 800h..7FFh
// - power summed into 40-bit signed accumulator
// - one accumulation every four master clocks
// - signed addition; negative power decreases energy
// - power mode places power in waveform
// - accumulator wraps both ways, flags half and wrap
// - ch1 scaled by one plus trim over 4096
// - 20-bit sample sign-extended, sent three bytes MSB-first
module emd_datapath
  import emd_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // adc samples
  input  wire emd_pair_s             adc_in,
  // configuration registers
  input  wire logic [MODE_W-1:0]     mode_reg,
  input  wire logic                  wave_source_select,
  input  wire logic                  sample_irq_enable,
  input  wire logic [TRIM_REG_W-1:0] phase_delay_trim,
  input  wire logic [GAIN_W-1:0]     power_gain_trim,
  // waveform byte readout
  output emd_byte_s                  wave_byte,
  input  wire logic                  wave_byte_ready,
  output logic                       irq_n,
  output logic                       wave_overrun,
  // results
  output logic [POWER_W-1:0]         active_power,
  output logic [ENERGY_W-1:0]        energy_accumulator,
  output logic                       energy_half_evt,
  output logic                       energy_wrap_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [MCLK_CNT_W-1:0]                 mclk_cnt;
    logic [TICK_CNT_W-1:0]                 tick_ph;
    logic [ADC_CNT_W-1:0]                  adc_cnt;
    logic [DEC_CNT_W-1:0]                  dec_cnt;
    logic [RING_AW-1:0]                    wptr;
    logic [RING_DEPTH-1:0][2*ADC_W-1:0]    ring;
    logic [POWER_W-1:0]                    p_inst;
    logic [CH2_WAVE_LOWPASS_ACC_W-1:0]                 ch2_wave_lowpass;
    logic [POWER_LOWPASS_ACC_W-1:0]                 power_lowpass;
    logic [ENERGY_W-1:0]                   energy;
    logic                                  half_evt;
    logic                                  wrap_evt;
    logic                                  pend;
    logic [WAVE_W-1:0]                     pend_word;
    logic                                  overrun;
    emd_rd_e                               rd;
    logic [WAVE_W-1:0]                     word;
    emd_byte_s                             obyte;
    logic                                  irq_n;
  } emd_state_s;

  emd_state_s s;
  emd_state_s next_s;

  logic                          mclk_en;
  logic                          acc_tick;
  logic                          adc_take;
  logic                          wave_take;
  logic                          cap_ok;
  logic [1:0]                    cap_sel;
  logic [1:0]                    rate_sel;
  logic [DEC_CNT_W-1:0]          dec_mask;
  logic [6:0]                    d2;
  logic [RING_AW-1:0]            idx1;
  logic [RING_AW-1:0]            idx2;
  logic signed [ADC_W-1:0]       ch1_dly;
  logic signed [ADC_W-1:0]       ch2_dly;
  logic signed [GPROD_W-1:0]     gain_prod;
  logic signed [SC_W-1:0]        ch1_sc;
  logic signed [PROD_W-1:0]      prod;
  logic signed [CH2_WAVE_LOWPASS_ACC_W:0]    ch2_wave_lowpass_sum;
  logic signed [POWER_LOWPASS_ACC_W:0]    power_lowpass_sum;
  logic signed [POWER_W-1:0]     power;
  logic [WAVE_W-1:0]             ch2_wave_lowpass_wave;
  logic [WAVE_W-1:0]             ch1_wave;
  logic [WAVE_W-1:0]             power_wave;
  logic [WAVE_W-1:0]             cap_word;
  logic [ENERGY_W-1:0]           energy_sum;
  logic                          fifo_in_ready;
  logic                          fifo_out_valid;
  logic [WAVE_W-1:0]             fifo_out_data;

  // clip to the 20-bit sample range and sign-extend to the waveform width
  function automatic logic [WAVE_W-1:0] clip_wave(
    input logic signed [WAVE_W-1:0] v
  );
    logic signed [WAVE_W-1:0] hi;
    logic signed [WAVE_W-1:0] lo;
    hi = WAVE_W'(24'sh07_FFFF);
    lo = WAVE_W'(-24'sh08_0000);
    if (v > hi) begin
      clip_wave = hi;
    end else if (v < lo) begin
      clip_wave = lo;
    end else begin
      clip_wave = v;
    end
  endfunction : clip_wave

  ////////////////////////////////////////////////////////////////////////////
  // timebase: master clock enable, accumulation tick, adc sample strobe

  assign mclk_en  = s.mclk_cnt == MCLK_CNT_W'(MCLK_DIV - 1);
  assign acc_tick = mclk_en && s.tick_ph == TICK_CNT_W'(MCLK_PER_TICK - 1);
  assign adc_take = acc_tick && s.adc_cnt == ADC_CNT_W'(TICKS_PER_ADC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // delay line, gain, multiplier

  always_comb begin
    d2      = DELAY_MID + {phase_delay_trim[TRIM_W-1], phase_delay_trim[5:0]};
    idx1    = s.wptr - DELAY_MID[RING_AW-1:0];
    idx2    = s.wptr - d2[RING_AW-1:0];
    ch1_dly = $signed(s.ring[idx1][2*ADC_W-1:ADC_W]);
    ch2_dly = $signed(s.ring[idx2][ADC_W-1:0]);
    gain_prod = ch1_dly * $signed(power_gain_trim);
    ch1_sc  = SC_W'(ch1_dly)
            + SC_W'($signed(gain_prod[GPROD_W-1:GAIN_FRAC]));
    prod    = ch1_sc * ch2_dly;
  end

  ////////////////////////////////////////////////////////////////////////////
  // recursive low-pass filters with saturation

  always_comb begin
    ch2_wave_lowpass_sum = (CH2_WAVE_LOWPASS_ACC_W+1)'($signed(s.ch2_wave_lowpass))
             + (CH2_WAVE_LOWPASS_ACC_W+1)'($signed(adc_in.ch2))
             - (CH2_WAVE_LOWPASS_ACC_W+1)'($signed(s.ch2_wave_lowpass) >>> CH2_WAVE_LOWPASS_SHIFT);
    power_lowpass_sum = (POWER_LOWPASS_ACC_W+1)'($signed(s.power_lowpass))
             + (POWER_LOWPASS_ACC_W+1)'($signed(s.p_inst))
             - (POWER_LOWPASS_ACC_W+1)'($signed(s.power_lowpass) >>> POWER_LOWPASS_SHIFT);
    power      = $signed(s.power_lowpass[POWER_LOWPASS_SHIFT +: POWER_W]);
    ch2_wave_lowpass_wave  = clip_wave(WAVE_W'($signed(s.ch2_wave_lowpass[CH2_WAVE_LOWPASS_SHIFT +: ADC_W])));
    ch1_wave   = clip_wave(WAVE_W'(ch1_sc));
    power_wave = clip_wave(power);
    energy_sum = s.energy + ENERGY_W'(power);
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform capture selection and decimation

  always_comb begin
    cap_sel  = mode_reg[MODE_CAP_LSB +: 2];
    rate_sel = mode_reg[MODE_RATE_LSB +: 2];
    unique case (rate_sel)
      2'h0: dec_mask = 3'h0;
      2'h1: dec_mask = 3'h1;
      2'h2: dec_mask = 3'h3;
      2'h3: dec_mask = 3'h7;
    endcase
    cap_ok = (cap_sel == CAP_POWER && wave_source_select)
          || cap_sel == CAP_CH1
          || (cap_sel == CAP_CH2 && wave_source_select);
    wave_take = adc_take && cap_ok && (s.dec_cnt & dec_mask) == '0;
    if (cap_sel == CAP_CH2) begin
      cap_word = ch2_wave_lowpass_wave;
    end else if (cap_sel == CAP_CH1) begin
      cap_word = ch1_wave;
    end else begin
      cap_word = power_wave;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s          = s;
    next_s.half_evt = 1'b0;
    next_s.wrap_evt = 1'b0;
    next_s.overrun  = 1'b0;
    next_s.mclk_cnt = mclk_en ? '0 : s.mclk_cnt + 1'b1;
    if (mclk_en) begin
      next_s.tick_ph = s.tick_ph + 1'b1;
    end
    if (acc_tick) begin
      next_s.ring[s.wptr] = {adc_in.ch1, adc_in.ch2};
      next_s.wptr         = s.wptr + 1'b1;
      next_s.adc_cnt      = s.adc_cnt + 1'b1;
      next_s.p_inst       = {prod[PROD_W-1], prod[PROD_W-1:POWER_SHIFT]};
      if (ch2_wave_lowpass_sum[CH2_WAVE_LOWPASS_ACC_W] != ch2_wave_lowpass_sum[CH2_WAVE_LOWPASS_ACC_W-1]) begin
        next_s.ch2_wave_lowpass = {ch2_wave_lowpass_sum[CH2_WAVE_LOWPASS_ACC_W], {(CH2_WAVE_LOWPASS_ACC_W-1){~ch2_wave_lowpass_sum[CH2_WAVE_LOWPASS_ACC_W]}}};
      end else begin
        next_s.ch2_wave_lowpass = ch2_wave_lowpass_sum[CH2_WAVE_LOWPASS_ACC_W-1:0];
      end
      if (power_lowpass_sum[POWER_LOWPASS_ACC_W] != power_lowpass_sum[POWER_LOWPASS_ACC_W-1]) begin
        next_s.power_lowpass = {power_lowpass_sum[POWER_LOWPASS_ACC_W], {(POWER_LOWPASS_ACC_W-1){~power_lowpass_sum[POWER_LOWPASS_ACC_W]}}};
      end else begin
        next_s.power_lowpass = power_lowpass_sum[POWER_LOWPASS_ACC_W-1:0];
      end
      next_s.energy   = energy_sum;
      next_s.wrap_evt = (s.energy[ENERGY_W-1] == power[POWER_W-1])
                     && (energy_sum[ENERGY_W-1] != s.energy[ENERGY_W-1]);
      next_s.half_evt = (energy_sum[ENERGY_W-1] ^ energy_sum[ENERGY_W-2])
                     && !(s.energy[ENERGY_W-1] ^ s.energy[ENERGY_W-2]);
    end
    if (adc_take) begin
      next_s.dec_cnt = s.dec_cnt + 1'b1;
    end
    // a waiting word leaves once the fifo takes it; a new one replaces it
    if (s.pend && fifo_in_ready) begin
      next_s.pend = 1'b0;
    end
    if (wave_take) begin
      next_s.pend      = 1'b1;
      next_s.pend_word = cap_word;
      next_s.overrun   = s.pend && !fifo_in_ready;
    end
    unique case (s.rd)
      RD_IDLE: begin
        if (fifo_out_valid) begin
          next_s.rd    = RD_HI;
          next_s.word  = fifo_out_data;
          next_s.obyte = '{data: fifo_out_data[23:16], valid: 1'b1, last: 1'b0};
        end
      end
      RD_HI: begin
        if (wave_byte_ready) begin
          next_s.rd    = RD_MID;
          next_s.obyte = '{data: s.word[15:8], valid: 1'b1, last: 1'b0};
        end
      end
      RD_MID: begin
        if (wave_byte_ready) begin
          next_s.rd    = RD_LO;
          next_s.obyte = '{data: s.word[7:0], valid: 1'b1, last: 1'b1};
        end
      end
      RD_LO: begin
        if (wave_byte_ready) begin
          next_s.rd    = RD_IDLE;
          next_s.obyte = '0;
        end
      end
    endcase
    next_s.irq_n = !(sample_irq_enable
                  && (fifo_out_valid || next_s.rd != RD_IDLE));
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s        <= '0;
      s.energy <= ENERGY_RST;
      s.rd     <= RD_IDLE;
      s.irq_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform buffer

  emd_fifo #(
    .W     (WAVE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (s.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (s.pend_word),
    .out_valid (fifo_out_valid),
    .out_ready (s.rd == RD_IDLE),
    .out_data  (fifo_out_data)
  );

  assign wave_byte          = s.obyte;
  assign irq_n              = s.irq_n;
  assign wave_overrun       = s.overrun;
  assign active_power       = s.power_lowpass[POWER_LOWPASS_SHIFT +: POWER_W];
  assign energy_accumulator = s.energy;
  assign energy_half_evt    = s.half_evt;
  assign energy_wrap_evt    = s.wrap_evt;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // adc periods since the last capture; only trusted while mode and rate hold
  logic [3:0] gap_cnt;
  logic [1:0] gap_rate;
  logic       gap_ok;
  logic       gap_live;

  assign gap_live = gap_ok && cap_ok && rate_sel == gap_rate;

  always_ff @(posedge core_clk) begin
    gap_rate <= rate_sel;
    if (!nrst) begin
      gap_cnt <= 4'h1;
      gap_ok  <= 1'b0;
    end else if (wave_take) begin
      gap_cnt <= 4'h1;
      gap_ok  <= 1'b1;
    end else if (!gap_live) begin
      gap_ok  <= 1'b0;
    end else if (adc_take && gap_cnt != 4'hF) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  sequence rd_hi_taken;
    s.rd == RD_HI && wave_byte_ready;
  endsequence
  sequence rd_mid_taken;
    s.rd == RD_MID && wave_byte_ready;
  endsequence

  ch2_wave_route_a: assert property (
    wave_take && cap_sel == CAP_CH2 |=> s.pend && s.pend_word == $past(ch2_wave_lowpass_wave))
    else $error("ch2 capture did not load filtered ch2 sample");
  ch2_lpf_hold_a: assert property (!acc_tick |=> $stable(s.ch2_wave_lowpass))
    else $error("ch2 waveform filter moved between ticks");
  mult_raw_ch2_a: assert property (
    acc_tick |=> s.p_inst == {$past(prod[PROD_W-1]), $past(prod[PROD_W-1:POWER_SHIFT])})
    else $error("instantaneous power not from raw product");
  rate_decim_a: assert property (
    wave_take && gap_live |-> gap_cnt == 4'(1 << rate_sel))
    else $error("capture spacing does not match selected rate");
  irq_on_sample_a: assert property (
    sample_irq_enable && fifo_out_valid |=> !irq_n)
    else $error("interrupt not asserted with sample waiting");
  delay_match_a: assert property (phase_delay_trim[5:0] == 6'h00 |-> idx1 == idx2)
    else $error("channel delays differ with zero trim");
  trim_advance_a: assert property (
    phase_delay_trim[5:0] == 6'h3F |-> idx2 == idx1 + 1'b1)
    else $error("minus one trim did not advance ch2 by one step");
  gain_unity_a: assert property (power_gain_trim == 12'h000 |-> ch1_sc == SC_W'(ch1_dly))
    else $error("zero gain trim changed ch1 sample");
  energy_add_a: assert property (
    acc_tick |=> s.energy == $past(s.energy) + ENERGY_W'($past(power)))
    else $error("energy did not add signed power");
  energy_hold_a: assert property (!acc_tick |=> $stable(s.energy))
    else $error("energy changed outside accumulation tick");
  tick_spacing_a: assert property (acc_tick |=> !acc_tick [*8])
    else $error("accumulation ticks too close");
  power_wave_a: assert property (
    wave_take && cap_sel == CAP_POWER |=> s.pend_word == $past(power_wave))
    else $error("power capture loaded wrong value");
  wrap_flag_a: assert property (
    acc_tick && $signed(power) > 0 && s.energy == 40'h7F_FFFF_FFFF
      |=> energy_wrap_evt && energy_accumulator[ENERGY_W-1])
    else $error("positive overflow did not wrap negative");
  byte_order_a: assert property (
    rd_hi_taken ##1 rd_mid_taken |=> wave_byte.last && wave_byte.data == s.word[7:0])
    else $error("waveform bytes not sent most significant first");
  rate_gap_a: assert property (
    adc_take && gap_live && gap_cnt == 4'(1 << rate_sel) |-> wave_take)
    else $error("capture missed its decimation slot");

endmodule : emd_datapath

// ---- test/emd_host_model.sv ----
// emd_host_model: host side that drains waveform bytes and rebuilds words
// assumes valid/ready is sampled on the rising core_clk edge
`timescale 1ns/100ps
module emd_host_model
  import emd_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // byte stream from the datapath
  input  wire emd_byte_s    wave_byte,
  output logic              wave_byte_ready = 1'b0,
  // pacing and results
  input  wire logic         slow,
  output logic [WAVE_W-1:0] word = '0,
  output int                words = 0,
  output int                bad = 0
);
  logic [WAVE_W-1:0] shift;
  int                idx;
  int                pace;

  //////////////////////////////////////////////////////////////////////////
  // slow pace stalls two cycles out of three
  always @(negedge core_clk) begin
    pace = (pace + 1) % 3;
    wave_byte_ready = !slow || (pace == 0);
  end

  always @(posedge core_clk) begin
    if (nrst !== 1'b1) begin
      idx = 0;
    end else if (wave_byte.valid === 1'b1 && wave_byte_ready) begin
      shift = {shift[WAVE_W-9:0], wave_byte.data};
      if (wave_byte.last === 1'b1) begin
        bad += (idx != 2);
        word = shift;
        words++;
        idx = 0;
      end else begin
        idx++;
      end
    end
  end
endmodule : emd_host_model

// ---- test/emd_datapath_bench.sv ----
// emd_datapath_bench: self-checking bench for the metering datapath
// assumes one tick every 108 core clocks and an adc word every 32 ticks
`timescale 1ns/100ps
module emd_datapath_bench
  import emd_pkg::*;
;
  localparam int              TICK = 108;
  localparam int              ADCP = 3456;
  localparam int              LIM  = 30000;
  localparam logic [ADC_W-1:0] KP  = 20'h2_851F;
  localparam logic [ADC_W-1:0] KN  = 20'hD_7AE1;
  logic                  core_clk = 1'b0;
  logic                  nrst = 1'b0;
  emd_pair_s             adc_in;
  logic [MODE_W-1:0]     mode_reg;
  logic                  wss, sie, slow, rdy, irq_n, ovr, half, wrap;
  logic [TRIM_REG_W-1:0] trim;
  logic [GAIN_W-1:0]     gain;
  emd_byte_s             wbyte;
  logic [POWER_W-1:0]    pwr, p_q;
  logic [ENERGY_W-1:0]   nrg, e_q;
  logic [WAVE_W-1:0]     word;
  int                    words, bad, failures, checked, cyc, t_last;
  bit                    have;

  always #5 core_clk = ~core_clk;

  emd_datapath DUT (.core_clk(core_clk), .nrst(nrst), .adc_in(adc_in),
    .mode_reg(mode_reg), .wave_source_select(wss),
    .sample_irq_enable(sie), .phase_delay_trim(trim),
    .power_gain_trim(gain), .wave_byte(wbyte), .wave_byte_ready(rdy),
    .irq_n(irq_n), .wave_overrun(ovr), .active_power(pwr),
    .energy_accumulator(nrg), .energy_half_evt(half),
    .energy_wrap_evt(wrap));

  emd_host_model host (.core_clk(core_clk), .nrst(nrst), .wave_byte(wbyte),
    .wave_byte_ready(rdy), .slow(slow), .word(word), .words(words),
    .bad(bad));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // each energy step adds the power held before it, on tick spacing
  always @(posedge core_clk) begin
    cyc++;
    if (nrst !== 1'b1) begin
      have = 0;
      t_last = 0;
    end else begin
      if (have && nrg !== e_q) begin
        check("energy", nrg, e_q + {{16{p_q[23]}}, p_q});
        if (t_last > 0) check("gap", 40'((cyc - t_last) % TICK), 40'h0);
        t_last = cyc;
      end
      if ({ovr, wrap, half} !== 3'h0) begin
        check("events", 40'({ovr, wrap, half}), 40'h0);
      end
      e_q = nrg;
      p_q = pwr;
      have = 1;
    end
  end

  task automatic do_reset();
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
  endtask : do_reset

  task automatic set_mode(input logic [1:0] cap, r, input logic s);
    mode_reg = 16'h0000;
    mode_reg[MODE_CAP_LSB +: 2] = cap;
    mode_reg[MODE_RATE_LSB +: 2] = r;
    wss = s;
  endtask : set_mode

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  //////////////////////////////////////////////////////////////////////////
  // cycles from a step on one channel to the first nonzero power
  task automatic lat_run(input bit s1, input logic [7:0] tr, output int n);
    adc_in.ch1 = s1 ? '0 : KN;
    adc_in.ch2 = s1 ? KP : '0;
    trim = tr;
    do_reset();
    idle(2 * TICK);
    if (s1) adc_in.ch1 = KP;
    else adc_in.ch2 = KP;
    n = 0;
    while (pwr === 24'h00_0000 && n < LIM) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= LIM) failures++;
  endtask : lat_run

  task automatic t_delay();
    int a, b, c;
    lat_run(1'b1, 8'h00, a);
    lat_run(1'b0, 8'h00, b);
    check("ch_delay", 40'(b), 40'(a));
    idle(2 * TICK);
    check("neg_energy", 40'(nrg[39]), 40'h1);
    lat_run(1'b0, 8'h3F, c);
    check("trim_step", 40'(b - c), 40'(TICK));
  endtask : t_delay

  task automatic t_gain();
    logic signed [23:0] hi, lo;
    adc_in.ch1 = KP;
    adc_in.ch2 = KP;
    trim = 8'h00;
    gain = 12'h7FF;
    do_reset();
    idle(45 * TICK);
    hi = pwr;
    gain = 12'h800;
    do_reset();
    idle(45 * TICK);
    lo = pwr;
    check("power_sign", 40'(lo[23]), 40'h0);
    check("gain_range", 40'(hi > lo), 40'h1);
  endtask : t_gain

  task automatic next_fall(output int n);
    n = 0;
    while (irq_n !== 1'b1 && n < LIM) begin
      @(negedge core_clk);
      n++;
    end
    while (irq_n !== 1'b0 && n < LIM) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= LIM) failures++;
  endtask : next_fall

  task automatic t_rates();
    int n;
    adc_in.ch2 = KN;
    sie = 1'b1;
    slow = 1'b0;
    for (int r = 0; r < 4; r++) begin
      set_mode(CAP_CH2, 2'(r), 1'b1);
      do_reset();
      next_fall(n);
      next_fall(n);
      check("rate_gap", 40'(n), 40'(ADCP << r));
      idle(8);
      check("ch2_sign", 40'(word[23]), 40'h1);
      check("ch2_lpf", 40'($signed(word) > $signed({{4{KN[19]}}, KN})),
            40'h1);
    end
  endtask : t_rates

  task automatic wait_word(input string nm);
    int w0, n;
    w0 = words;
    n = 0;
    while (words == w0 && n < LIM) begin
      @(negedge core_clk);
      n++;
    end
    check(nm, 40'(words - w0), 40'h1);
    check("sign_ext", 40'(word[23:19]), 40'({5{word[19]}}));
  endtask : wait_word

  task automatic t_modes();
    int w0, lows;
    slow = 1'b1;
    set_mode(CAP_POWER, 2'h0, 1'b1);
    idle(100);
    wait_word("power_word");
    set_mode(CAP_CH1, 2'h0, 1'b0);
    sie = 1'b0;
    idle(100);
    w0 = words;
    lows = 0;
    repeat (ADCP + 100) begin
      @(negedge core_clk);
      lows += (irq_n !== 1'b1);
    end
    check("ch1_word", 40'(words > w0), 40'h1);
    check("irq_gated", 40'(lows), 40'h0);
    sie = 1'b1;
    for (int m = 0; m < 3; m++) begin
      set_mode(m == 0 ? CAP_CH2 : m == 1 ? CAP_POWER : 2'h1, 2'h0, m == 2);
      idle(100);
      w0 = words;
      idle(ADCP + 100);
      check("no_word", 40'(words - w0), 40'h0);
    end
    check("frames", 40'(bad), 40'h0);
  endtask : t_modes

  //////////////////////////////////////////////////////////////////////////
  initial begin
    adc_in = '0;
    mode_reg = 16'h0000;
    wss = 1'b0;
    sie = 1'b0;
    slow = 1'b0;
    trim = 8'h00;
    gain = 12'h000;
    t_delay();
    t_gain();
    t_rates();
    t_modes();
    finish_test();
  end

  initial begin
    repeat (130000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule : emd_datapath_bench
